// ==== hw/diwc_top.sv ====
// Purpose: Deep idle wake-up control and clock gating of the standby mode.
// Assumes: pclk is the main oscillator clock and keeps running in deep idle.
// Notes:   Registers are reached over APB with zero wait states.
`timescale 1ns/100ps

module diwc_top #(
    parameter int SETUP_BASE = diwc_pkg::SETUP_BASE_DFLT,
    parameter int CNT_W      = 24
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    // APB slave.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Non-maskable request pins, asynchronous.
    input  wire logic [diwc_pkg::NMI_N-1:0] nmi_pin,
    // Interrupt controller and CPU, same clock.
    input  wire logic                      irq_pend,
    input  wire logic [2:0]                irq_pend_prio,
    input  wire logic                      irq_pend_pin3,
    input  wire logic                      in_service,
    input  wire logic [2:0]                service_prio,
    input  wire logic                      irq_globally_enabled,
    // Wake outcome toward the CPU.
    output logic                           wake_ack,
    output logic                           take_handler,
    output logic                           resume_next,
    output logic                           deep_idle,
    // Clock gating and hold controls.
    output logic                           cpu_clk_en,
    output logic                           pll_clk_en,
    output logic                           flash_clk_en,
    output logic                           irq_ctrl_normal,
    output logic                           irq_wake_detect,
    output logic                           gtimer_run,
    output logic                           watch_run,
    output logic [1:0]                     csi_run,
    output logic [1:0]                     uart_run,
    output logic                           adc_freeze,
    output logic                           port_hold,
    output logic                           retain_state
);

    // ==========================================================
    // State record

    typedef struct packed {
        diwc_pkg::diwc_state_e          st;
        logic [diwc_pkg::NMI_N-1:0]     nmi_meta;
        logic [diwc_pkg::NMI_N-1:0]     nmi_sync;
        logic                           nmi0_dis;
        logic                           nmi1_dis;
        logic                           irq_dis;
        logic [diwc_pkg::MODE_W-1:0]    mode;
        logic [diwc_pkg::STAB_W-1:0]    stab;
        logic                           flt_en;
        logic [diwc_pkg::FLT_SEL_W-1:0] flt_sel;
        logic [diwc_pkg::CLKSEL_W-1:0]  clksel;
        logic                           wake;
        logic                           wake_nmi;
        logic                           was_nmi;
        logic                           dec_ack;
        logic                           dec_handler;
        logic                           pending_kept;
        logic                           ack;
        logic                           handler;
        logic                           next;
        logic [31:0]                    rdata;
        logic                           err;
    } diwc_top_s;

    diwc_top_s cur_ff;
    diwc_top_s nxt_cur;

    logic       cnt_start;
    logic       cnt_done;
    logic [4:0] cnt_shift;

    // ==========================================================
    // Helpers

    // Tells whether an APB address hits one register word.
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Tells whether an address belongs to the register map at all.
    function automatic logic addr_mapped(input logic [7:0] a);
        return addr_hit(a, diwc_pkg::OFF_PWC) || addr_hit(a, diwc_pkg::OFF_MODE)
            || addr_hit(a, diwc_pkg::OFF_STAB) || addr_hit(a, diwc_pkg::OFF_FLT)
            || addr_hit(a, diwc_pkg::OFF_CLKSEL) || addr_hit(a, diwc_pkg::OFF_STATUS);
    endfunction

    // ==========================================================
    // Wake qualification

    logic nmi_wake;
    logic pin3_blocked;
    logic mask_wake;
    logic lower_prio;
    logic in_idle;
    logic setup_q;
    logic wr_acc;
    logic rd_setup;

    // Qualifies the wake sources against their disable bits and the filter.
    always_comb begin
        nmi_wake     = |(cur_ff.nmi_sync & ~{cur_ff.nmi1_dis, cur_ff.nmi0_dis});
        pin3_blocked = cur_ff.flt_en && (cur_ff.flt_sel >= diwc_pkg::FLT_SLOW_MIN);
        mask_wake    = irq_pend && !cur_ff.irq_dis
                       && !(irq_pend_pin3 && pin3_blocked);
        lower_prio   = in_service && (irq_pend_prio >= service_prio);
        in_idle      = cur_ff.st == diwc_pkg::ST_IDLE;
        setup_q      = cur_ff.st == diwc_pkg::ST_SETUP;
        wr_acc       = psel && penable && pwrite;
        rd_setup     = psel && !penable && !pwrite;
    end

    // ==========================================================
    // Next-state logic

    always_comb begin
        nxt_cur         = cur_ff;
        nxt_cur.ack     = 1'b0;
        nxt_cur.handler = 1'b0;
        nxt_cur.next    = 1'b0;
        cnt_start       = 1'b0;

        // Two-stage synchroniser on the request pins.
        nxt_cur.nmi_meta = nmi_pin;
        nxt_cur.nmi_sync = cur_ff.nmi_meta;

        // Wake requests are registered once while idle; priority does not matter.
        nxt_cur.wake     = in_idle && (nmi_wake || mask_wake);
        nxt_cur.wake_nmi = in_idle && nmi_wake;

        // Register writes; control bits are only changed while running.
        if (wr_acc && cur_ff.st == diwc_pkg::ST_RUN) begin
            if (addr_hit(paddr, diwc_pkg::OFF_PWC)) begin
                nxt_cur.nmi0_dis = pwdata[diwc_pkg::PWC_NMI0_DIS_BIT];
                nxt_cur.nmi1_dis = pwdata[diwc_pkg::PWC_NMI1_DIS_BIT];
                nxt_cur.irq_dis  = pwdata[diwc_pkg::PWC_IRQ_DIS_BIT];
                // Entry needs the mode bits set to deep idle beforehand.
                if (pwdata[diwc_pkg::PWC_TRIGGER_BIT]
                    && cur_ff.mode == diwc_pkg::MODE_DEEP_IDLE) begin
                    nxt_cur.st = diwc_pkg::ST_IDLE;
                end
            end
            if (addr_hit(paddr, diwc_pkg::OFF_MODE)) begin
                nxt_cur.mode = pwdata[diwc_pkg::MODE_W-1:0];
            end
            if (addr_hit(paddr, diwc_pkg::OFF_STAB)) begin
                nxt_cur.stab = pwdata[diwc_pkg::STAB_W-1:0];
            end
            if (addr_hit(paddr, diwc_pkg::OFF_FLT)) begin
                nxt_cur.flt_en  = pwdata[diwc_pkg::FLT_EN_BIT];
                nxt_cur.flt_sel = pwdata[diwc_pkg::FLT_SEL_W-1:0];
            end
            if (addr_hit(paddr, diwc_pkg::OFF_CLKSEL)) begin
                nxt_cur.clksel = pwdata[diwc_pkg::CLKSEL_W-1:0];
            end
        end

        // Controller sequence.
        unique case (cur_ff.st)
            diwc_pkg::ST_RUN: begin
                nxt_cur.pending_kept = 1'b0;
            end
            diwc_pkg::ST_IDLE: begin
                // The registered wake starts the setup counter.
                if (cur_ff.wake) begin
                    nxt_cur.st      = diwc_pkg::ST_SETUP;
                    cnt_start       = 1'b1;
                    nxt_cur.was_nmi = cur_ff.wake_nmi;
                    if (cur_ff.wake_nmi) begin
                        // Non-maskable: always acknowledged and vectored.
                        nxt_cur.dec_ack     = 1'b1;
                        nxt_cur.dec_handler = 1'b1;
                    end else if (lower_prio) begin
                        // Lower priority inside a handler stays pending.
                        nxt_cur.dec_ack      = 1'b0;
                        nxt_cur.dec_handler  = 1'b0;
                        nxt_cur.pending_kept = 1'b1;
                    end else begin
                        // Accepted only while interrupts are globally enabled.
                        nxt_cur.dec_ack     = irq_globally_enabled;
                        nxt_cur.dec_handler = irq_globally_enabled;
                    end
                end
            end
            diwc_pkg::ST_SETUP: begin
                // Fetch resumes only on overflow of the setup counter.
                if (cnt_done) begin
                    nxt_cur.st      = diwc_pkg::ST_RUN;
                    nxt_cur.ack     = cur_ff.dec_ack;
                    nxt_cur.handler = cur_ff.dec_handler;
                    nxt_cur.next    = !cur_ff.dec_handler;
                end
            end
            default: begin
                nxt_cur.st = diwc_pkg::ST_RUN;
            end
        endcase

        // Read data is captured in the setup cycle for a zero-wait access.
        nxt_cur.err = psel && !penable && !addr_mapped(paddr);
        if (rd_setup) begin
            nxt_cur.rdata = '0;
            if (addr_hit(paddr, diwc_pkg::OFF_PWC)) begin
                nxt_cur.rdata[diwc_pkg::PWC_NMI0_DIS_BIT] = cur_ff.nmi0_dis;
                nxt_cur.rdata[diwc_pkg::PWC_NMI1_DIS_BIT] = cur_ff.nmi1_dis;
                nxt_cur.rdata[diwc_pkg::PWC_IRQ_DIS_BIT]  = cur_ff.irq_dis;
            end
            if (addr_hit(paddr, diwc_pkg::OFF_MODE)) begin
                nxt_cur.rdata[diwc_pkg::MODE_W-1:0] = cur_ff.mode;
            end
            if (addr_hit(paddr, diwc_pkg::OFF_STAB)) begin
                nxt_cur.rdata[diwc_pkg::STAB_W-1:0] = cur_ff.stab;
            end
            if (addr_hit(paddr, diwc_pkg::OFF_FLT)) begin
                nxt_cur.rdata[diwc_pkg::FLT_EN_BIT]        = cur_ff.flt_en;
                nxt_cur.rdata[diwc_pkg::FLT_SEL_W-1:0]     = cur_ff.flt_sel;
            end
            if (addr_hit(paddr, diwc_pkg::OFF_CLKSEL)) begin
                nxt_cur.rdata[diwc_pkg::CLKSEL_W-1:0] = cur_ff.clksel;
            end
            if (addr_hit(paddr, diwc_pkg::OFF_STATUS)) begin
                nxt_cur.rdata[diwc_pkg::ST_IDLE_BIT]    = in_idle;
                nxt_cur.rdata[diwc_pkg::ST_SETUP_BIT]   = setup_q;
                nxt_cur.rdata[diwc_pkg::ST_NMI_BIT]     = cur_ff.was_nmi;
                nxt_cur.rdata[diwc_pkg::ST_PENDING_BIT] = cur_ff.pending_kept;
            end
        end
    end

    // ==========================================================
    // State register

    // Reset ends deep idle through the same path as any reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff      <= '0;
            cur_ff.st   <= diwc_pkg::ST_RUN;
            cur_ff.mode <= diwc_pkg::MODE_RESET;
            cur_ff.stab <= diwc_pkg::STAB_RESET;
        end else if (clk_en) begin
            cur_ff <= nxt_cur;
        end
    end

    // ==========================================================
    // Setup period counter

    assign cnt_shift = 5'(SETUP_BASE) + 5'(cur_ff.stab);

    diwc_setup_counter #(
        .WIDTH   (CNT_W)
    ) u_setup (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .start   (cnt_start),
        .shift   (cnt_shift),
        .busy    (),
        .done    (cnt_done)
    );

    // ==========================================================
    // Clock gating and hold controls

    // PLL and flash regain their clocks during setup; the CPU only after it.
    always_comb begin
        cpu_clk_en      = cur_ff.st == diwc_pkg::ST_RUN;
        pll_clk_en      = !in_idle;
        flash_clk_en    = !in_idle;
        irq_ctrl_normal = !in_idle;
        irq_wake_detect = 1'b1;
        gtimer_run      = !in_idle || cur_ff.clksel[diwc_pkg::CS_GT_FN8_BIT]
                          || (cur_ff.clksel[diwc_pkg::CS_GT_INTOSC_BIT]
                              && cur_ff.clksel[diwc_pkg::CS_SUBCLK_BIT]);
        watch_run       = !in_idle || cur_ff.clksel[diwc_pkg::CS_SUBCLK_BIT]
                          || cur_ff.clksel[diwc_pkg::CS_WT_DIVMAIN_BIT];
        csi_run[0]      = !in_idle || cur_ff.clksel[diwc_pkg::CS_CSI0_EXT_BIT];
        csi_run[1]      = !in_idle || cur_ff.clksel[diwc_pkg::CS_CSI1_EXT_BIT];
        uart_run[0]     = !in_idle || cur_ff.clksel[diwc_pkg::CS_UART0_EXT_BIT];
        uart_run[1]     = !in_idle;
        adc_freeze      = in_idle;
        port_hold       = in_idle;
        retain_state    = in_idle || setup_q;
    end

    // ==========================================================
    // Outputs

    assign deep_idle    = in_idle;
    assign wake_ack     = cur_ff.ack;
    assign take_handler = cur_ff.handler;
    assign resume_next  = cur_ff.next;
    assign prdata       = cur_ff.rdata;
    assign pslverr      = cur_ff.err && psel && penable;
    assign pready       = 1'b1;

endmodule

// ==== shared/diwc_pkg.sv ====
// Purpose: Constants and types of the deep idle wake-up controller.
// Assumes: One clock, pclk at 250 MHz, which is the main oscillator clock.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
//
// Notes on behaviour
// - Any non-maskable or unmasked maskable request ends deep idle, whatever its priority.
// - A source whose disable bit is 1 is ignored and never ends deep idle.
// - Pin 3 cannot wake while its noise filter samples at divide-by-64 or slower.
// - Inside a handler, a lower-priority request wakes but stays pending, not acknowledged.
// - Inside a handler, a higher-priority or non-maskable request wakes and is acknowledged.
// - A non-maskable wake jumps to its handler after setup, enabled or not.
// - Maskable wake with interrupts enabled: handler or next instruction, by priority.
// - Maskable wake with interrupts disabled resumes at the next instruction after setup.
// - Reset during deep idle ends it exactly as an ordinary reset does.
// - The interrupt controller stops normal work but still detects wake requests.
// - General timer runs only on divided-by-8 clock, or internal oscillator with subclock.
// - Watch timer runs on divided main clock, or always when the subclock is used.
// - Each clocked serial channel runs only on its external serial clock.
// - Async serial channels stop, except channel 0 on its external baud clock.
// - The analog converter freezes and keeps its last result.
// - Port pins hold their levels and directions from just before entry.
// - CPU registers, flags and RAM contents are kept unchanged.
// - A flash setup wait is inserted before instruction fetch resumes.
// - A setup counter counts the selected period; operation resumes on its overflow.

package diwc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_PWC      = 8'h00;
    localparam logic [7:0] OFF_MODE     = 8'h04;
    localparam logic [7:0] OFF_STAB     = 8'h08;
    localparam logic [7:0] OFF_FLT      = 8'h0c;
    localparam logic [7:0] OFF_CLKSEL   = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;

    // ==========================================================
    // Power save control fields
    localparam int PWC_NMI0_DIS_BIT = 0;
    localparam int PWC_NMI1_DIS_BIT = 1;
    localparam int PWC_IRQ_DIS_BIT  = 4;
    localparam int PWC_TRIGGER_BIT  = 7;

    // Mode select field and the deep idle code.
    localparam int         MODE_W          = 2;
    localparam logic [1:0] MODE_DEEP_IDLE  = 2'h2;
    localparam logic [1:0] MODE_RESET      = 2'h0;

    // Setup period select: period is 2 to the power of (base + select).
    localparam int         STAB_W          = 3;
    localparam logic [2:0] STAB_RESET      = 3'h6;
    localparam int         SETUP_BASE_DFLT = 10;

    // Noise filter control: enable bit and sampling clock select.
    localparam int         FLT_EN_BIT      = 7;
    localparam int         FLT_SEL_W       = 3;
    localparam logic [2:0] FLT_SLOW_MIN    = 3'h3;

    // Peripheral clock source selections.
    localparam int CLKSEL_W          = 7;
    localparam int CS_GT_FN8_BIT     = 0;
    localparam int CS_GT_INTOSC_BIT  = 1;
    localparam int CS_WT_DIVMAIN_BIT = 2;
    localparam int CS_SUBCLK_BIT     = 3;
    localparam int CS_CSI0_EXT_BIT   = 4;
    localparam int CS_CSI1_EXT_BIT   = 5;
    localparam int CS_UART0_EXT_BIT  = 6;

    // Status fields.
    localparam int ST_IDLE_BIT    = 0;
    localparam int ST_SETUP_BIT   = 1;
    localparam int ST_NMI_BIT     = 2;
    localparam int ST_PENDING_BIT = 3;

    localparam int PRIO_W = 3;
    localparam int NMI_N  = 2;

    // ==========================================================
    // Controller states.
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_IDLE  = 3'b010,
        ST_SETUP = 3'b100
    } diwc_state_e;

endpackage

// ==== hw/diwc_setup_counter.sv ====
// Purpose: Setup period counter that runs after a wake from deep idle.
// Assumes: Start is a one-cycle pulse; shift selects a period of 2**shift cycles.
// Notes:   Done is a one-cycle pulse on overflow of the count.
`timescale 1ns/100ps

module diwc_setup_counter #(
    parameter int WIDTH = 24
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             start,
    input  wire logic [4:0]       shift,
    output logic                  busy,
    output logic                  done
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic [WIDTH-1:0] limit;
        logic             busy;
        logic             done;
    } diwc_cnt_s;

    diwc_cnt_s cur_ff;
    diwc_cnt_s nxt_cur;

    // Counts from zero to the limit and pulses done on overflow.
    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.done = 1'b0;
        if (start) begin
            nxt_cur.count = '0;
            nxt_cur.limit = (WIDTH'(1) << shift) - WIDTH'(1);
            nxt_cur.busy  = 1'b1;
        end else if (cur_ff.busy) begin
            if (cur_ff.count == cur_ff.limit) begin
                nxt_cur.busy = 1'b0;
                nxt_cur.done = 1'b1;
            end else begin
                nxt_cur.count = cur_ff.count + WIDTH'(1);
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
        end else if (clk_en) begin
            cur_ff <= nxt_cur;
        end
    end

    assign busy = cur_ff.busy;
    assign done = cur_ff.done;

endmodule

// ==== testbench/diwc_host_model.sv ====
// Purpose: Interrupt controller side model holding one maskable request.
// Assumes: One clock; raise and drop are one-cycle strobes.
// Notes:   A request leaves only when acknowledged or dropped.
`timescale 1ns/100ps

// ========
// Pending request model.
module diwc_host_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raise,
    input  wire logic drop,
    input  wire logic wake_ack,
    output logic      irq_pend
);
    // An unacknowledged request stays pending.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_pend <= 1'b0;
        else if (raise)
            irq_pend <= 1'b1;
        else if (wake_ack || drop)
            irq_pend <= 1'b0;
    end
endmodule

// ==== testbench/diwc_sva.sv ====
// Purpose: Assertions on wake outcome and gating outputs.
// Assumes: Setup period of at least 4 cycles and at most 600.
// Notes:   Sees only the top module ports.
`timescale 1ns/100ps

// ========
// Checker.
module diwc_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       deep_idle,
    input wire logic       cpu_clk_en,
    input wire logic       pll_clk_en,
    input wire logic       flash_clk_en,
    input wire logic       irq_ctrl_normal,
    input wire logic       irq_wake_detect,
    input wire logic       take_handler,
    input wire logic       resume_next,
    input wire logic       wake_ack,
    input wire logic       port_hold,
    input wire logic       retain_state,
    input wire logic       adc_freeze,
    input wire logic [1:0] uart_run
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Gating and hold while idle.
    property p_gate; deep_idle |-> !cpu_clk_en && !pll_clk_en && !flash_clk_en; endproperty
    a_gate: assert property (p_gate) else $error("clock runs in deep idle");
    property p_intc; deep_idle |-> !irq_ctrl_normal && irq_wake_detect; endproperty
    a_intc: assert property (p_intc) else $error("irq controller mode wrong");
    property p_hold; deep_idle |-> port_hold && retain_state && adc_freeze; endproperty
    a_hold: assert property (p_hold) else $error("state not held");
    property p_uart; deep_idle |-> !uart_run[1]; endproperty
    a_uart: assert property (p_uart) else $error("async channel 1 runs");
    // Setup wait after leaving idle.
    property p_wait; $fell(deep_idle) && !cpu_clk_en |-> !cpu_clk_en [*4]; endproperty
    a_wait: assert property (p_wait) else $error("setup too short");
    property p_bound; $fell(deep_idle) && !cpu_clk_en |-> ##[1:600] cpu_clk_en; endproperty
    a_bound: assert property (p_bound) else $error("setup never ends");
    // Wake outcome pulses.
    property p_one; take_handler |-> !resume_next && cpu_clk_en; endproperty
    a_one: assert property (p_one) else $error("two outcomes");
    property p_ack; wake_ack |-> take_handler; endproperty
    a_ack: assert property (p_ack) else $error("ack without handler");
    property p_pulse; take_handler || resume_next |=> !take_handler && !resume_next; endproperty
    a_pulse: assert property (p_pulse) else $error("outcome not a pulse");
    c_th: cover property (take_handler);
    c_rn: cover property (resume_next);
    c_ack: cover property (wake_ack);
endmodule

bind diwc_top diwc_sva u_sva (.pclk, .presetn, .deep_idle, .cpu_clk_en, .pll_clk_en,
    .flash_clk_en, .irq_ctrl_normal, .irq_wake_detect, .take_handler, .resume_next,
    .wake_ack, .port_hold, .retain_state, .adc_freeze, .uart_run);

// ==== testbench/diwc_bench.sv ====
// Purpose: Self-checking bench of the deep idle wake-up controller.
// Assumes: APB answers with pready; setup shortened by SETUP_BASE 2.
// Notes:   Each wake case enters deep idle through the registers.
`timescale 1ns/100ps

module diwc_bench;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, perr, irq_pend, pin3 = 1'b0, in_service = 1'b0;
    logic        irq_en = 1'b0, raise = 1'b0, drop = 1'b0;
    logic [1:0]  nmi_pin = 2'h0, csi_run, uart_run;
    logic [2:0]  prio = 3'h0, sprio = 3'h0;
    logic        wake_ack, take_handler, resume_next, deep_idle, cpu_clk_en, pll_clk_en;
    logic        flash_clk_en, irq_ctrl_normal, irq_wake_detect, gtimer_run, watch_run;
    logic        adc_freeze, port_hold, retain_state;
    int          n_errors = 0, comparisons = 0, cyc = 0;

    diwc_top #(.SETUP_BASE(2)) u_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nmi_pin, .irq_pend,
        .irq_pend_prio(prio), .irq_pend_pin3(pin3), .in_service, .service_prio(sprio),
        .irq_globally_enabled(irq_en), .wake_ack, .take_handler, .resume_next, .deep_idle,
        .cpu_clk_en, .pll_clk_en, .flash_clk_en, .irq_ctrl_normal, .irq_wake_detect,
        .gtimer_run, .watch_run, .csi_run, .uart_run, .adc_freeze, .port_hold, .retain_state);
    diwc_host_model u_host (.pclk, .presetn, .raise, .drop, .wake_ack, .irq_pend);

    // Clock of 4 ns.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Hang guard.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; read data and error kept in q and perr.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic enter(input logic [31:0] dis);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h00, 32'h80 | dis);
        do @(posedge pclk); while (deep_idle !== 1'b1);
    endtask

    // Enter, raise one request, check the outcome and the kept request.
    task automatic wake(input logic nmi, input logic [2:0] p, input logic sv,
                        input logic [2:0] sp, input logic e, input logic th, input logic ak);
        prio <= p;
        in_service <= sv;
        sprio <= sp;
        irq_en <= e;
        enter(32'h0);
        if (nmi)
            nmi_pin <= 2'h2;
        else
            raise <= 1'b1;
        @(posedge pclk);
        raise <= 1'b0;
        do @(posedge pclk); while (take_handler !== 1'b1 && resume_next !== 1'b1);
        chk("take_handler", take_handler, th);
        chk("resume_next", resume_next, !th);
        chk("wake_ack", wake_ack, ak);
        nmi_pin <= 2'h0;
        @(posedge pclk);
        chk("irq_pend", irq_pend, !nmi && !ak);
        drop <= 1'b1;
        @(posedge pclk);
        drop <= 1'b0;
        $display("wake case done");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        chk("osc_stabilize_select", q, 32'h6);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", perr, 32'h1);
        chk("unmapped_rd", q, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        $display("register test done");
        wake(1'b1, 3'h0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
        wake(1'b0, 3'h2, 1'b0, 3'h0, 1'b1, 1'b1, 1'b1);
        wake(1'b0, 3'h2, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
        wake(1'b0, 3'h3, 1'b1, 3'h1, 1'b1, 1'b0, 1'b0);
        wake(1'b0, 3'h1, 1'b1, 3'h3, 1'b1, 1'b1, 1'b1);
        wake(1'b1, 3'h0, 1'b1, 3'h3, 1'b1, 1'b1, 1'b1);
        // All disable bits set: nothing wakes; reset ends deep idle.
        enter(32'h13);
        nmi_pin <= 2'h3;
        raise <= 1'b1;
        @(posedge pclk);
        raise <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("deep_idle", deep_idle, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk("status", q, 32'h5);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("cpu_clk_en", {deep_idle, cpu_clk_en}, 32'h1);
        // Filtered pin 3 refused while chosen peripherals keep running.
        apb(1'b1, 8'h0c, 32'h83);
        apb(1'b1, 8'h10, 32'h51);
        enter(32'h3);
        pin3 <= 1'b1;
        raise <= 1'b1;
        @(posedge pclk);
        raise <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("deep_idle", deep_idle, 32'h1);
        chk("runs", {gtimer_run, watch_run, csi_run, uart_run}, 32'h25);
        pin3 <= 1'b0;
        do @(posedge pclk); while (take_handler !== 1'b1);
        chk("wake_ack", wake_ack, 32'h1);
        $display("refusal test done");
        test_done();
    end
endmodule
